/* design/tsr_regs.sv */
/*
 * register set of a temperature sensor with thermal alarm, reached over
 * a two-wire serial slave whose clock and data pins are sampled by clk.
 * assumes a converter outside that gives a one-cycle conv_done with the
 * 9-bit reading on conv_data, and an open-drain pad driven from sda_oe.
 */
// Overview of operation
// - select byte with bits 7..2 set aborts
// - select value kept between transactions
// - low select bits choose one of four registers
// - select value clears to zero at reset
// - reading register is 16 bits, read only
// - settings reset zero, bit 7 reserved, 6..5 stored as written
// - fault 4..3, polarity 2, mode 1, standby 0
// - mode 0 comparator, mode 1 latched interrupt
// - a finished conversion refreshes the reading unless a read is shifting out
// - conversion always judged, stored only when not reading
// - sign at bit 15, reading in 15..7
// - reading bits below bit 7 read zero
// - reading is zero until first conversion
// - upper trip point resets to 5000 hex
// - lower trip point resets to 4B00 hex
// - only top nine trip bits are compared
// - registers stay reachable during standby
// - reading is 9-bit two's complement, half degree
// - fault codes need 1, 2, 4, 6 hits
// - interrupt mode alarm clears on any read, unless a hit lands in the same cycle
// - standby finishes and stores conversion in progress
`timescale 1ns/1ps
module tsr_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] addr_pins,
	input wire logic conv_done,
	input wire tsr_pkg::tsr_temp_t conv_data,
	output logic conv_enable,
	output logic alarm_out,
	output logic alarm_oe
);
	import tsr_pkg::*;

	logic scl_s, sda_s; // synchronised pins
	logic scl_d, sda_d; // one cycle older copies for edge finding
	logic [2:0] addr_s; // synchronised address straps
	logic scl_rise, scl_fall, start_c, stop_c;
	tsr_state_t state, next_state; // serial engine
	logic [3:0] bit_cnt, next_bit_cnt; // bits of the current byte
	logic [7:0] shreg, next_shreg; // receive and transmit shifter
	logic [1:0] byte_idx, next_byte_idx; // data byte within transfer
	logic rw, next_rw; // transfer direction, 1 is read
	logic ack_ok, next_ack_ok; // master acknowledged the last byte
	logic drive, next_drive; // pulling sda low
	logic [1:0] ptr, next_ptr; // register select value
	logic [7:0] settings, next_settings; // device_settings
	logic [15:0] upper, next_upper; // upper_trip_point
	logic [15:0] lower, next_lower; // lower_trip_point
	logic [7:0] wr_hi, next_wr_hi; // first byte of a 16-bit write
	logic read_strobe; // a register read begins
	logic ptr_load, ptr_abort; // select byte taken or refused
	logic standby_enter; // standby bit going to one
	logic read_busy; // data is being shifted out
	tsr_temp_t reading, next_reading; // stored 9-bit reading
	logic [15:0] reading_word; // reading as seen on the bus
	logic [2:0] fault_cnt, next_fault_cnt; // consecutive hits
	logic [2:0] fault_need; // hits needed for this setting
	logic hunt_low, next_hunt_low; // looking for under lower limit
	logic active, next_active; // alarm asserted, before polarity
	logic next_alarm_out;
	logic fault_hit; // this conversion completed the needed consecutive hits
	logic limit_met; // conversion is past the limit sought

	// pins cross into clk through two flip-flops each
	tsr_sync #(.W(2), .INIT(2'h3)) u_sync_bus (
		.clk(clk),
		.rst(rst),
		.async_in({scl_in, sda_in}),
		.sync_out({scl_s, sda_s})
	);
	tsr_sync #(.W(3), .INIT(3'h0)) u_sync_addr (
		.clk(clk),
		.rst(rst),
		.async_in(addr_pins),
		.sync_out(addr_s)
	);

	// bus edges and conditions, from synchronised copies only
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
	assign read_busy = (state == TSR_RDATA) || (state == TSR_RACK);
	// reading sits at 15..7 with zero padding below
	assign reading_word = {reading, TSR_READ_PAD};
	assign sda_out = 1'b0; // open drain: only ever pulls low
	assign sda_oe = drive;
	assign alarm_oe = ~alarm_out; // pulled low when the level is low
	assign conv_enable = ~settings[TSR_CFG_STANDBY];

	// byte returned for a read of the selected register
	function automatic logic [7:0] read_byte(input logic [1:0] sel,
		input logic [1:0] idx);
		logic [15:0] word;
		word = 16'h0000;
		if (sel == TSR_PTR_READING) begin
			word = reading_word;
		end else if (sel == TSR_PTR_LOWER) begin
			word = lower;
		end else if (sel == TSR_PTR_UPPER) begin
			word = upper;
		end else begin
			word = {settings, 8'h00};
		end
		if (idx == 2'h0) begin
			read_byte = word[15:8];
		end else if (idx == 2'h1 && sel != TSR_PTR_SETTINGS) begin
			read_byte = word[7:0];
		end else begin
			read_byte = 8'h00; // past the end of the register
		end
	endfunction

	// serial engine and register writes, next values
	always_comb begin
		logic [7:0] tx;
		tx = 8'h00;
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_byte_idx = byte_idx;
		next_rw = rw;
		next_ack_ok = ack_ok;
		next_drive = drive;
		next_ptr = ptr;
		next_settings = settings;
		next_upper = upper;
		next_lower = lower;
		next_wr_hi = wr_hi;
		read_strobe = 1'b0;
		ptr_load = 1'b0;
		ptr_abort = 1'b0;
		if (start_c) begin
			// start or repeated start: new address byte
			next_state = TSR_ADDR;
			next_bit_cnt = 4'h0;
			next_drive = 1'b0;
		end else if (stop_c) begin
			next_state = TSR_IDLE;
			next_drive = 1'b0;
		end else begin
			case (state)
				TSR_ADDR, TSR_PTR, TSR_WDATA: begin
					// shift in on rise, act on the fall after bit 8
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_s};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == TSR_BITS_PER_BYTE) begin
						next_bit_cnt = 4'h0;
						if (state == TSR_ADDR) begin
							if (shreg[7:1] == {TSR_ADDR_PREFIX, addr_s}) begin
								next_rw = shreg[0];
								next_drive = 1'b1;
								next_state = TSR_ADDR_ACK;
							end else begin
								next_state = TSR_IDLE; // not ours
							end
						end else if (state == TSR_PTR) begin
							if (shreg[TSR_SEL_TOP:TSR_SEL_LOW] != 6'h00) begin
								ptr_abort = 1'b1;
								next_state = TSR_IDLE;
							end else begin
								next_ptr = shreg[1:0];
								ptr_load = 1'b1;
								next_drive = 1'b1;
								next_state = TSR_PTR_ACK;
							end
						end else begin
							// data byte: commit to the selected register
							next_drive = 1'b1;
							next_state = TSR_WDATA_ACK;
							if (byte_idx != 2'h2) begin
								next_byte_idx = byte_idx + 2'h1;
							end
							if (ptr == TSR_PTR_SETTINGS) begin
								if (byte_idx == 2'h0) begin
									// reserved bit kept zero
									next_settings = shreg & TSR_CFG_WR_MASK;
								end
							end else if (byte_idx == 2'h0) begin
								next_wr_hi = shreg;
							end else if (byte_idx == 2'h1) begin
								if (ptr == TSR_PTR_UPPER) begin
									next_upper = {wr_hi, shreg};
								end else if (ptr == TSR_PTR_LOWER) begin
									next_lower = {wr_hi, shreg};
								end
								// reading register: write dropped
							end
						end
					end
				end
				TSR_ADDR_ACK, TSR_PTR_ACK, TSR_WDATA_ACK: begin
					// release acknowledge on the falling edge
					if (scl_fall) begin
						next_bit_cnt = 4'h0;
						next_drive = 1'b0;
						if (state == TSR_ADDR_ACK && rw) begin
							tx = read_byte(ptr, 2'h0);
							next_shreg = tx;
							next_drive = ~tx[7];
							next_bit_cnt = 4'h1;
							next_byte_idx = 2'h1;
							read_strobe = 1'b1;
							next_state = TSR_RDATA;
						end else if (state == TSR_ADDR_ACK) begin
							next_state = TSR_PTR;
						end else begin
							if (state == TSR_PTR_ACK) begin
								next_byte_idx = 2'h0;
							end
							next_state = TSR_WDATA;
						end
					end
				end
				TSR_RDATA: begin
					// next bit out on each falling edge
					if (scl_fall) begin
						if (bit_cnt == TSR_BITS_PER_BYTE) begin
							next_drive = 1'b0;
							next_state = TSR_RACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_drive = ~shreg[6];
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				TSR_RACK: begin
					// master ack continues, nack ends the read
					if (scl_rise) begin
						next_ack_ok = ~sda_s;
					end else if (scl_fall) begin
						if (ack_ok) begin
							tx = read_byte(ptr, byte_idx);
							next_shreg = tx;
							next_drive = ~tx[7];
							next_bit_cnt = 4'h1;
							if (byte_idx != 2'h2) begin
								next_byte_idx = byte_idx + 2'h1;
							end
							next_state = TSR_RDATA;
						end else begin
							next_state = TSR_IDLE;
						end
					end
				end
				default: begin
					next_state = TSR_IDLE;
				end
			endcase
		end
		// standby does not block the engine
		standby_enter = next_settings[TSR_CFG_STANDBY] &
			~settings[TSR_CFG_STANDBY];
	end

	// serial engine and register storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= TSR_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			byte_idx <= 2'h0;
			rw <= 1'b0;
			ack_ok <= 1'b0;
			drive <= 1'b0;
			ptr <= TSR_PTR_RESET;
			settings <= TSR_CFG_RESET;
			upper <= TSR_UPPER_RESET;
			lower <= TSR_LOWER_RESET;
			wr_hi <= 8'h00;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			byte_idx <= next_byte_idx;
			rw <= next_rw;
			ack_ok <= next_ack_ok;
			drive <= next_drive;
			ptr <= next_ptr;
			settings <= next_settings;
			upper <= next_upper;
			lower <= next_lower;
			wr_hi <= next_wr_hi;
		end
	end

	// hits needed per fault-count code
	always_comb begin
		case (settings[TSR_CFG_FAULT_HI:TSR_CFG_FAULT_LO])
			2'h0: fault_need = TSR_FAULT_NEED_0;
			2'h1: fault_need = TSR_FAULT_NEED_1;
			2'h2: fault_need = TSR_FAULT_NEED_2;
			default: fault_need = TSR_FAULT_NEED_3;
		endcase
	end

	// reading store and alarm evaluation, next values
	always_comb begin
		next_reading = reading;
		next_fault_cnt = fault_cnt;
		next_hunt_low = hunt_low;
		next_active = active;
		fault_hit = 1'b0;
		// only the top nine trip bits matter
		limit_met = hunt_low ?
			($signed(conv_data) < $signed(lower[TSR_READ_TOP:TSR_READ_BOT])) :
			($signed(conv_data) > $signed(upper[TSR_READ_TOP:TSR_READ_BOT]));
		if (conv_done) begin
			// stored only while no read is shifting out
			if (!read_busy) begin
				next_reading = conv_data;
			end
			// every conversion is judged
			if (limit_met) begin
				if (fault_cnt + 3'h1 >= fault_need) begin
					fault_hit = 1'b1;
					next_fault_cnt = 3'h0;
					next_hunt_low = ~hunt_low;
					// comparator follows the hunt, interrupt latches
					next_active = settings[TSR_CFG_MODE] ? 1'b1 : ~hunt_low;
				end else begin
					next_fault_cnt = fault_cnt + 3'h1;
				end
			end else begin
				next_fault_cnt = 3'h0;
			end
		end
		// interrupt mode: read or standby clears, a new hit wins
		if (settings[TSR_CFG_MODE] && (read_strobe || standby_enter) &&
			!fault_hit) begin
			next_active = 1'b0;
		end
		next_alarm_out = settings[TSR_CFG_POLARITY] ? next_active :
			~next_active;
	end

	// reading and alarm storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reading <= TSR_READING_RESET;
			fault_cnt <= 3'h0;
			hunt_low <= 1'b0;
			active <= 1'b0;
			alarm_out <= 1'b1;
		end else begin
			reading <= next_reading;
			fault_cnt <= next_fault_cnt;
			hunt_low <= next_hunt_low;
			active <= next_active;
			alarm_out <= next_alarm_out;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_abort;
		ptr_abort |=> state == TSR_IDLE && $stable(ptr);
	endproperty
	a_abort: assert property (p_abort) else $error("select abort");
	property p_ptr_hold;
		!ptr_load |=> $stable(ptr);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("select moved");
	property p_store;
		conv_done && !read_busy |=> reading == $past(conv_data);
	endproperty
	a_store: assert property (p_store) else $error("reading lost");
	property p_hold_read;
		conv_done && read_busy |=> $stable(reading);
	endproperty
	a_hold_read: assert property (p_hold_read) else $error("read torn");
	property p_only_conv;
		$changed(reading) |-> $past(conv_done);
	endproperty
	a_only_conv: assert property (p_only_conv) else $error("bad write");
	property p_reserved;
		settings[TSR_CFG_RESERVED] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved set");
	property p_int_clear;
		settings[TSR_CFG_MODE] && read_strobe && !fault_hit |=> !active;
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("no clear");
	property p_rise_cause;
		$rose(active) |-> $past(conv_done) && $past(fault_cnt) + 3'h1 >=
			$past(fault_need);
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("early alarm");
	property p_defaults;
		$past(rst) |-> upper == TSR_UPPER_RESET && lower == TSR_LOWER_RESET
			&& ptr == TSR_PTR_RESET && reading == TSR_READING_RESET;
	endproperty
	a_defaults: assert property (p_defaults) else $error("bad reset");
	c_ptr: cover property (ptr_load ##[1:600] read_strobe);
	c_alarm: cover property ($rose(active));
	c_upper: cover property ($changed(upper));
endmodule

/* design/tsr_pkg.sv */
/*
 * constants and types shared by the temperature sensor register set:
 * pointer codes, register layouts, reset values and fault counts.
 * assumes nothing of its surroundings.
 */
package tsr_pkg;
	// register select codes carried in the two low select bits
	localparam logic [1:0] TSR_PTR_READING = 2'h0; // temperature_reading
	localparam logic [1:0] TSR_PTR_SETTINGS = 2'h1; // device_settings
	localparam logic [1:0] TSR_PTR_LOWER = 2'h2; // lower_trip_point
	localparam logic [1:0] TSR_PTR_UPPER = 2'h3; // upper_trip_point
	localparam logic [1:0] TSR_PTR_RESET = 2'h0; // power-up selection
	// select byte bits that must stay zero
	localparam int TSR_SEL_TOP = 7;
	localparam int TSR_SEL_LOW = 2;
	// device_settings field positions
	localparam int TSR_CFG_RESERVED = 7;
	localparam int TSR_CFG_FAULT_HI = 4;
	localparam int TSR_CFG_FAULT_LO = 3;
	localparam int TSR_CFG_POLARITY = 2;
	localparam int TSR_CFG_MODE = 1;
	localparam int TSR_CFG_STANDBY = 0;
	localparam logic [7:0] TSR_CFG_RESET = 8'h00;
	localparam logic [7:0] TSR_CFG_WR_MASK = 8'h7F; // reserved bit stays 0
	// trip point reset values
	localparam logic [15:0] TSR_UPPER_RESET = 16'h5000;
	localparam logic [15:0] TSR_LOWER_RESET = 16'h4B00;
	localparam logic [8:0] TSR_READING_RESET = 9'h000;
	// reading field: 9 bits at 15..7, zeros below
	localparam int TSR_READ_TOP = 15;
	localparam int TSR_READ_BOT = 7;
	localparam logic [6:0] TSR_READ_PAD = 7'h00;
	// consecutive out-of-limit conversions per fault-count code
	localparam logic [2:0] TSR_FAULT_NEED_0 = 3'h1;
	localparam logic [2:0] TSR_FAULT_NEED_1 = 3'h2;
	localparam logic [2:0] TSR_FAULT_NEED_2 = 3'h4;
	localparam logic [2:0] TSR_FAULT_NEED_3 = 3'h6;
	// serial slave address: fixed upper four bits, then three strap pins
	localparam logic [3:0] TSR_ADDR_PREFIX = 4'h9;
	localparam logic [3:0] TSR_BITS_PER_BYTE = 4'h8;
	// serial engine states, gray coded along the write path
	typedef enum logic [3:0] {
		TSR_IDLE = 4'h0,
		TSR_ADDR = 4'h1,
		TSR_ADDR_ACK = 4'h3,
		TSR_PTR = 4'h2,
		TSR_PTR_ACK = 4'h6,
		TSR_WDATA = 4'h7,
		TSR_WDATA_ACK = 4'h5,
		TSR_RDATA = 4'h4,
		TSR_RACK = 4'hC
	} tsr_state_t;
	typedef logic [8:0] tsr_temp_t; // 9-bit two's complement, half degree
endpackage

/* design/tsr_sync.sv */
/*
 * two flip-flop synchroniser for a group of pin inputs.
 * assumes the inputs are asynchronous to clk; reset value is a parameter.
 */
`timescale 1ns/1ps
module tsr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1; // first stage, read only by the second
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_sync_out;

	// next values are just the shifted inputs
	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	// two stages, reset to the idle level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= INIT;
			sync_out <= INIT;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule

/* tb/tsr_bus_master.sv */
/*
 * behavioural two-wire bus master driving the sensor's serial pins.
 * assumes clk is the 200 MHz bench clock; one bus bit is 32 cycles.
 */
`timescale 1ns/1ps
module tsr_bus_master (
	input wire logic clk,
	input wire logic dev_pull,
	output logic scl,
	output logic sda,
	output logic got,
	output logic [7:0] got_val,
	output logic rd_phase
);
	logic m_pull; // master pulls data low
	// open-drain line with pull-up: low while either side pulls
	assign sda = ~(dev_pull | m_pull);
	// idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		m_pull = 1'b0;
		got = 1'b0;
		got_val = 8'h00;
		rd_phase = 1'b0;
	end
	// a quarter of the 160 ns bit
	task automatic qtr();
		repeat (8) @(posedge clk);
	endtask
	// data changes only while clock is low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		m_pull <= ~b;
		qtr();
		scl <= 1'b1;
		qtr();
		r = sda;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask
	// data falls while clock high
	task automatic start();
		m_pull <= 1'b0;
		qtr();
		scl <= 1'b1;
		qtr();
		m_pull <= 1'b1;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask
	// data rises while clock high, then bus free time
	task automatic stop();
		m_pull <= 1'b1;
		qtr();
		scl <= 1'b1;
		qtr();
		m_pull <= 1'b0;
		qtr();
	endtask
	// eight bits plus ack; reports read byte or ack seen (1 = acked)
	task automatic byte_io(input logic [7:0] d, input logic mack,
		input logic rd);
		logic [7:0] r;
		logic a;
		rd_phase <= rd;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(mack, a);
		rd_phase <= 1'b0;
		got_val <= rd ? r : {7'h00, ~a};
		got <= 1'b1;
		@(posedge clk);
		got <= 1'b0;
	endtask
endmodule

/* tb/temp_sensor_register_set_tb.sv */
/*
 * self-checking bench for the sensor register set: expectations go
 * into a queue, a watcher compares them with bytes and alarm pins.
 * assumes the bus master model and the package are compiled first.
 */
`timescale 1ns/1ps
module temp_sensor_register_set_tb;
	import tsr_pkg::*;
	logic clk;
	logic rst;
	logic scl;
	logic sda;
	logic sda_oe;
	logic [2:0] addr_pins;
	logic conv_done;
	tsr_temp_t conv_data;
	logic conv_enable;
	logic alarm_out;
	logic sda_out; // must stay low: the pad only ever pulls
	logic alarm_oe; // alarm pad pull enable
	logic got;
	logic [7:0] got_val;
	logic rd_phase;
	logic probe; // asks the watcher to sample the alarm pins
	logic [7:0] exp_q[$]; // expected results, oldest first
	int bad_count;
	int n_checks;
	int unsigned seed_use;
	logic [15:0] v;
	tsr_temp_t t;
	tsr_temp_t hot; // above upper trip
	tsr_temp_t cold; // below lower trip
	logic [2:0] need [4];
	logic alarm_polarity;

	tsr_regs dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(addr_pins),
		.conv_done(conv_done), .conv_data(conv_data),
		.conv_enable(conv_enable), .alarm_out(alarm_out),
		.alarm_oe(alarm_oe));
	tsr_bus_master m (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda),
		.got(got), .got_val(got_val), .rd_phase(rd_phase));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// an empty queue yields unknown so the compare fails
	function automatic logic [7:0] pop();
		if (exp_q.size() == 0) return 8'hXX;
		return exp_q.pop_front();
	endfunction
	// watcher: each reported byte takes the oldest note, each probe the two oldest
	always @(posedge clk) begin
		if (got) chk(got_val, pop());
		if (probe) chk({6'h00, conv_enable, alarm_out}, pop());
		if (probe) chk({6'h00, sda_out, alarm_oe}, pop());
	end

	task automatic send(input logic [7:0] b, input logic [7:0] e);
		exp_q.push_back(e);
		m.byte_io(b, 1'b1, 1'b0);
	endtask
	task automatic recv(input logic [7:0] e, input logic mack);
		exp_q.push_back(e);
		m.byte_io(8'hFF, mack, 1'b1);
	endtask
	// select byte then nb data bytes; a dirty select byte is refused
	task automatic wr(input logic [7:0] pb, input int nb,
		input logic [15:0] d);
		logic ok;
		ok = (pb[TSR_SEL_TOP:TSR_SEL_LOW] == 6'h00);
		m.start();
		send({TSR_ADDR_PREFIX, addr_pins, 1'b0}, 8'h01);
		send(pb, {7'h00, ok});
		if (ok && nb > 1) send(d[15:8], 8'h01);
		if (ok && nb > 0) send(d[7:0], 8'h01);
		m.stop();
	endtask
	// read nb bytes, high first, last one not acked
	task automatic rd(input int nb, input logic [15:0] d);
		m.start();
		send({TSR_ADDR_PREFIX, addr_pins, 1'b1}, 8'h01);
		if (nb > 1) recv(d[15:8], 1'b0);
		recv(d[7:0], 1'b1);
		m.stop();
	endtask
	// conversions land between accesses unless a scenario says else
	task automatic conv(input tsr_temp_t x);
		conv_data <= x;
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// e = {6'h00, conv_enable, alarm_out}
	task automatic look(input logic [7:0] e);
		exp_q.push_back(e);
		// open drain: pad pulls while the alarm level is low
		exp_q.push_back({7'h00, ~e[0]});
		probe <= 1'b1;
		@(posedge clk);
		probe <= 1'b0;
		@(posedge clk);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// hang guard, well beyond the expected run of about 37000 cycles
	initial begin
		repeat (80000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		conv_done = 1'b0;
		conv_data = '0;
		probe = 1'b0;
		bad_count = 0;
		n_checks = 0;
		need = '{TSR_FAULT_NEED_0, TSR_FAULT_NEED_1, TSR_FAULT_NEED_2,
			TSR_FAULT_NEED_3};
		seed_use = $urandom(90971);
		addr_pins = 3'($urandom);
		hot = 9'h033;
		cold = 9'h027;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// power-up contents
		look(8'h03);
		rd(2, {TSR_READING_RESET, TSR_READ_PAD});
		wr(8'h01, 0, 16'h0000);
		rd(1, {8'h00, TSR_CFG_RESET});
		wr(8'h02, 0, 16'h0000);
		rd(2, TSR_LOWER_RESET);
		rd(2, TSR_LOWER_RESET);
		wr(8'h03, 0, 16'h0000);
		rd(2, TSR_UPPER_RESET);
		// trip registers and refused select bytes
		v = 16'($urandom);
		wr(8'h03, 2, v);
		for (int b = 2; b < 8; b++) begin
			wr(8'h01 | (8'h01 << b), 1, 16'h00AA);
		end
		rd(2, v);
		v = 16'($urandom);
		wr(8'h02, 2, v);
		rd(2, v);
		wr(8'h00, 2, 16'hFFFF);
		rd(2, 16'h0000);
		// conversions with limits out of reach
		wr(8'h02, 2, 16'h8000);
		wr(8'h03, 2, 16'h7FFF);
		wr(8'h00, 0, 16'h0000);
		repeat (3) begin
			t = 9'($urandom);
			conv(t);
			rd(2, {t, TSR_READ_PAD});
		end
		// conversion during a read is judged but not stored
		wr(8'h03, 2, 16'h197F);
		wr(8'h02, 2, 16'h1400);
		wr(8'h00, 0, 16'h0000);
		fork
			rd(2, {t, TSR_READ_PAD});
			begin
				wait (rd_phase);
				conv(hot);
			end
		join
		look(8'h02);
		rd(2, {t, TSR_READ_PAD});
		conv(cold);
		look(8'h03);
		// every fault count, polarity alternating
		for (int c = 0; c < 4; c++) begin
			alarm_polarity = c[0];
			wr(8'h01, 1, {11'h000, 2'(c), alarm_polarity, 2'h0});
			repeat (need[c] - 1) conv(hot);
			look({7'h01, ~alarm_polarity});
			conv(hot);
			look({7'h01, alarm_polarity});
			repeat (need[c] - 1) conv(cold);
			look({7'h01, alarm_polarity});
			conv(cold);
			look({7'h01, ~alarm_polarity});
		end
		// latched interrupt mode
		wr(8'h01, 1, 16'h0002);
		conv(hot);
		look(8'h02);
		rd(1, 16'h0002);
		look(8'h03);
		conv(hot);
		look(8'h03);
		conv(cold);
		look(8'h02);
		wr(8'h01, 1, 16'h0003);
		look(8'h01);
		rd(1, 16'h0003);
		wr(8'h01, 1, 16'h009D);
		rd(1, 16'h001D);
		look(8'h00);
		// a conversion finishing in standby is still stored
		wr(8'h00, 0, 16'h0000);
		conv(cold);
		rd(2, {cold, TSR_READ_PAD});
		tally_and_finish();
	end
endmodule
